// >>> verif/iobf_host_model.sv
// Host processor model driving the I/O bus side of the block
`timescale 1ns/100ps
module iobf_host_model
    import iobf_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire iobf_pkg::iobf_pins_out_s pins_out,
    output iobf_pkg::iobf_pins_in_s       pins_in
);
    import iobf_pkg::*;
    int   cyc;
    int   lag;
    logic drv;
    logic [17:0] trap_pc;

    initial begin
        pins_in = '0;
        trap_pc = '1;
        cyc = 0;
        lag = 2;
        drv = 1'b0;
    end

    // Timing pulse every 200 cycles; released bus word keeps changing
    always @(posedge core_clk) begin
        cyc <= (cyc == 199) ? 0 : cyc + 1;
        pins_in.io_sync <= (cyc < 4);
        if (!drv) pins_in.io_bus <= ~pins_in.io_bus;
    end

    // Accepted service interrupt: trap to 000000, then fetch from 000001
    always @(posedge core_clk) begin
        if (pins_out.service_interrupt_bus_request && trap_pc != 18'h0 && trap_pc != 18'h1) begin
            trap_pc <= 18'h0;
        end else if (trap_pc == 18'h0) begin
            trap_pc <= 18'h1;
        end
    end

    // Serve a pending request after lag cycles
    always @(posedge core_clk) begin
        if (pins_out.device_to_host_bus_request || pins_out.host_to_device_bus_request) begin
            repeat (lag) @(posedge core_clk);
            pins_in.device_match <= 1'b1;
            pins_in.read_pulse <= pins_out.device_to_host_bus_request;
            pins_in.write_pulse <= !pins_out.device_to_host_bus_request;
            repeat (9) @(posedge core_clk);
            pins_in.read_pulse <= 1'b0;
            pins_in.write_pulse <= 1'b0;
            pins_in.device_match <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
    end

    // Skip test instruction for one subdevice code
    task skip_test(input logic [1:0] sd, output logic s);
        @(posedge core_clk);
        drv <= 1'b1;
        @(posedge core_clk);
        pins_in.io_bus[12] <= sd[1];
        pins_in.io_bus[13] <= sd[0];
        pins_in.device_match <= 1'b1;
        repeat (3) @(posedge core_clk);
        pins_in.flag_test_pulse <= 1'b1;
        repeat (8) @(posedge core_clk);
        s = pins_out.skip_bus_request;
        pins_in.flag_test_pulse <= 1'b0;
        pins_in.device_match <= 1'b0;
        repeat (8) @(posedge core_clk);
        drv <= 1'b0;
    endtask : skip_test

    // Select strobe with a held bus word
    task strobe(input logic [0:IOBF_BUS_W-1] w);
        @(posedge core_clk);
        drv <= 1'b1;
        @(posedge core_clk);
        pins_in.io_bus <= w;
        pins_in.device_match <= 1'b1;
        repeat (3) @(posedge core_clk);
        pins_in.select_strobe <= 1'b1;
        repeat (5) @(posedge core_clk);
        pins_in.select_strobe <= 1'b0;
        pins_in.device_match <= 1'b0;
        repeat (5) @(posedge core_clk);
        drv <= 1'b0;
    endtask : strobe

    // Power clear or count end held six cycles
    task pulse(input logic pc);
        @(posedge core_clk);
        if (pc) pins_in.power_clear <= 1'b1; else pins_in.transfer_count_end <= 1'b1;
        repeat (6) @(posedge core_clk);
        pins_in.power_clear <= 1'b0;
        pins_in.transfer_count_end <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : pulse
endmodule : iobf_host_model

// >>> verif/iobf_top_asserts.sv
// Checker for the I/O bus flag and request logic
`timescale 1ns/100ps
module iobf_top_asserts
    import iobf_pkg::*;
(
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire iobf_pkg::iobf_pins_in_s  pins_in,
    input wire iobf_pkg::iobf_pins_out_s pins_out,
    input wire iobf_pkg::iobf_mode_s     mode,
    input wire logic                    run,
    input wire logic                    irq
);
    import iobf_pkg::*;
    logic [3:0] sync_hist;

    // Recent samples of the host timing pulse
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_hist <= 4'h0;
        end else begin
            sync_hist <= {sync_hist[2:0], pins_in.io_sync};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Bus slave never stalls and never errors
    a_bus_okay: assert property (hreadyout && hresp == IOBF_HRESP_OKAY)
        else $error("bus slave not ready or not okay");
    a_pclr_clears: assert property ($past(pins_in.power_clear, 5) && $past(pins_in.power_clear, 6) &&
        $past(pins_in.power_clear, 7) |-> pins_out == 4'h0 && mode == 5'h0 && !run && !irq)
        else $error("state survives power clear");
    a_skip_needs_test: assert property (pins_out.skip_bus_request |-> $past(pins_in.flag_test_pulse, 4) ||
        $past(pins_in.flag_test_pulse, 5) || $past(pins_in.flag_test_pulse, 6) || $past(pins_in.flag_test_pulse, 7))
        else $error("skip without flag test pulse");
    a_skip_subdev: assert property ($rose(pins_out.skip_bus_request) |-> !$past(pins_in.io_bus[12], 5))
        else $error("skip for foreign subdevice");
    a_skip_release: assert property (!pins_in.flag_test_pulse [*8] |-> !pins_out.skip_bus_request)
        else $error("skip held after test pulse");
    a_int_on_sync: assert property ($rose(pins_out.service_interrupt_bus_request) |-> |sync_hist[3:1])
        else $error("interrupt request off sync");
    a_read_on_sync: assert property ($rose(pins_out.device_to_host_bus_request) |-> |sync_hist[3:1])
        else $error("read request off sync");
    a_write_on_sync: assert property ($rose(pins_out.host_to_device_bus_request) |-> |sync_hist[3:1])
        else $error("write request off sync");
    a_mode_on_strobe: assert property ($changed(mode) |-> $past(pins_in.select_strobe, 4) ||
        $past(pins_in.select_strobe, 5) || $past(pins_in.select_strobe, 6) || $past(pins_in.power_clear, 5))
        else $error("mode changed without strobe");
    a_read_drop: assert property ((pins_in.read_pulse && pins_in.device_match) [*8]
        |-> !pins_out.device_to_host_bus_request)
        else $error("read request not dropped");
    a_write_drop: assert property ((pins_in.write_pulse && pins_in.device_match) [*8]
        |-> !pins_out.host_to_device_bus_request)
        else $error("write request not dropped");
endmodule : iobf_top_asserts

bind iobf_top iobf_top_asserts u_asserts (.core_clk(core_clk), .sys_rst(sys_rst), .hreadyout(hreadyout),
    .hresp(hresp), .pins_in(pins_in), .pins_out(pins_out), .mode(mode), .run(run), .irq(irq));

// >>> verif/iobf_top_tb.sv
// Testbench for the I/O bus flag and request logic
`timescale 1ns/100ps
module iobf_top_tb;
    import iobf_pkg::*;
    logic core_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, run, irq;
    logic mem_add_valid, mem_old_sign, mem_new_sign, word_ready;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic s;
    iobf_pins_in_s pins_in;
    iobf_pins_out_s pins_out;
    iobf_mode_s mode;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [0:IOBF_BUS_W-1] w;

    assign hready = hreadyout;
    iobf_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins_in(pins_in), .pins_out(pins_out),
        .mem_add_valid(mem_add_valid), .mem_old_sign(mem_old_sign), .mem_new_sign(mem_new_sign),
        .word_ready(word_ready), .mode(mode), .run(run), .irq(irq));
    iobf_host_model u_host (.core_clk(core_clk), .pins_out(pins_out), .pins_in(pins_in));

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            stop_test();
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Single AHB-Lite word transfer
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= IOBF_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb

    task rd_chk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk("register", e, r);
    endtask : rd_chk

    task wait_pin(input int i, input logic v);
        int n;
        n = 0;
        while (pins_out[i] !== v && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk("request pin", {31'h0, v}, {31'h0, pins_out[i]});
    endtask : wait_pin

    task mem_add;
        @(posedge core_clk);
        mem_add_valid <= 1'b1;
        mem_new_sign <= 1'b1;
        @(posedge core_clk);
        mem_add_valid <= 1'b0;
    endtask : mem_add

    task t_reset;
        for (int i = 0; i < 5; i++) rd_chk((i == 4) ? 32'h20 : 32'(i * 4), 32'h0);
    endtask : t_reset

    task t_mode;
        w = '0;
        w[10] = 1'b1;
        w[6] = 1'b1;
        u_host.strobe(w);
        rd_chk(32'h4, 32'h3);
        w[10] = 1'b0;
        w[8] = 1'b1;
        w[15] = 1'b1;
        u_host.strobe(w);
        rd_chk(32'h4, 32'h16);
        chk("mode", 32'h16, {27'h0, mode});
    endtask : t_mode

    task t_sign;
        mem_add();
        rd_chk(32'h8, 32'h1);
        u_host.skip_test(IOBF_SD_SIGN, s);
        chk("skip sign", 32'h1, {31'h0, s});
        u_host.skip_test(IOBF_SD_COUNT, s);
        chk("skip count", 32'h0, {31'h0, s});
        ahb(1'b1, 32'h8, 32'h7);
        u_host.strobe('0);
        mem_add();
        rd_chk(32'h8, 32'h0);
    endtask : t_sign

    task t_count;
        ahb(1'b1, 32'h0, 32'h2);
        u_host.pulse(1'b0);
        rd_chk(32'h8, 32'h2);
        rd_chk(32'h0, 32'h0);
        chk("run", 32'h0, {31'h0, run});
        u_host.skip_test(IOBF_SD_COUNT, s);
        chk("skip count", 32'h1, {31'h0, s});
    endtask : t_count

    task t_irq;
        ahb(1'b1, 32'hc, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("irq", 32'h1, {31'h0, irq});
        ahb(1'b1, 32'h0, 32'h1);
        wait_pin(3, 1'b1);
        ahb(1'b1, 32'hc, 32'h0);
        chk("trap fetch", 32'h1, {14'h0, u_host.trap_pc});
        repeat (3) @(posedge core_clk);
        chk("irq", 32'h0, {31'h0, irq});
        ahb(1'b1, 32'h8, 32'h2);
        wait_pin(3, 1'b0);
    endtask : t_irq

    task t_xfer;
        ahb(1'b1, 32'h0, 32'h2);
        @(posedge core_clk);
        word_ready <= 1'b1;
        @(posedge core_clk);
        word_ready <= 1'b0;
        wait_pin(2, 1'b1);
        chk("run", 32'h1, {31'h0, run});
        wait_pin(2, 1'b0);
        u_host.lag = 30;
        ahb(1'b1, 32'h0, 32'h6);
        wait_pin(1, 1'b1);
        wait_pin(1, 1'b0);
        rd_chk(32'h0, 32'h2);
    endtask : t_xfer

    task t_pclr;
        ahb(1'b1, 32'hc, 32'h7);
        u_host.pulse(1'b1);
        rd_chk(32'hc, 32'h0);
        rd_chk(32'h0, 32'h0);
    endtask : t_pclr

    initial begin
        sys_rst = 1'b1;
        {hsel, hwrite, mem_add_valid, mem_old_sign, mem_new_sign, word_ready} = '0;
        {haddr, hwdata} = '0;
        htrans = 2'h0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_mode();
        t_sign();
        t_count();
        t_irq();
        t_xfer();
        t_pclr();
        stop_test();
    end
endmodule : iobf_top_tb

// >>> verilog/iobf_pkg.sv
// Package for the I/O bus flag and request logic: register map, field positions, pin carriers
package iobf_pkg;
    // Register byte offsets
    localparam logic [7:0] IOBF_CTRL_OFS  = 8'h00;
    localparam logic [7:0] IOBF_MODE_OFS  = 8'h04;
    localparam logic [7:0] IOBF_STAT_OFS  = 8'h08;
    localparam logic [7:0] IOBF_MASK_OFS  = 8'h0c;
    localparam logic [7:0] IOBF_STATE_OFS = 8'h10;
    localparam int         IOBF_AW        = 8;

    // Control register fields
    localparam int IOBF_CTRL_INT_EN = 0;
    localparam int IOBF_CTRL_RUN    = 1;
    localparam int IOBF_CTRL_WR_ARM = 2;
    localparam logic [2:0] IOBF_CTRL_RST = 3'h0;

    // Event bits, shared by status and mask
    localparam int IOBF_EV_SIGN  = 0;
    localparam int IOBF_EV_COUNT = 1;
    localparam int IOBF_EV_WORD  = 2;
    localparam int IOBF_NEV      = 3;
    localparam logic [2:0] IOBF_EV_RST = 3'h0;

    // Bus word bits, numbered 0 (msb side) to 17
    localparam int IOBF_BUS_W      = 18;
    localparam int IOBF_BIT_MEM_EN = 6;
    localparam int IOBF_BIT_EXT    = 8;
    localparam int IOBF_BIT_SCAN   = 10;
    localparam int IOBF_BIT_SD_HI  = 12;
    localparam int IOBF_BIT_SD_LO  = 13;
    localparam int IOBF_BIT_GAIN0  = 14;
    localparam int IOBF_BIT_GAIN1  = 15;

    // Subdevice codes
    localparam logic [1:0] IOBF_SD_SIGN  = 2'h0;
    localparam logic [1:0] IOBF_SD_COUNT = 2'h1;

    // AHB-Lite encodings
    localparam logic [1:0] IOBF_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] IOBF_HTRANS_SEQ    = 2'h3;
    localparam logic       IOBF_HRESP_OKAY    = 1'b0;

    // Pins arriving from the host I/O bus
    typedef struct packed {
        logic                  io_sync;
        logic                  power_clear;
        logic                  flag_test_pulse;
        logic                  read_pulse;
        logic                  write_pulse;
        logic                  select_strobe;
        logic                  transfer_count_end;
        logic                  device_match;
        logic [0:IOBF_BUS_W-1] io_bus;
    } iobf_pins_in_s;

    // Bus driver outputs toward the host
    typedef struct packed {
        logic service_interrupt_bus_request;
        logic device_to_host_bus_request;
        logic host_to_device_bus_request;
        logic skip_bus_request;
    } iobf_pins_out_s;

    // Mode settings latched by the select strobe
    typedef struct packed {
        logic [1:0] gain;
        logic       ext_sync;
        logic       mem_en;
        logic       scan_order_select;
    } iobf_mode_s;
endpackage : iobf_pkg

// >>> verilog/iobf_top.sv
// I/O bus flag, skip and request logic with an AHB-Lite register slave
// Operation
// - Set sign-change flag when an add-to-memory result changes sign.
// - Sign-change skip test with flag set requests a skip.
// - Raise a service interrupt and drive it on the bus driver.
// - Power clear initialises every control flip-flop and register.
// - Device-to-host word: assert read request on its bus driver.
// - Host-to-device word: assert write request on its bus driver.
// - Decode two subdevice lines from instruction bits 12 and 13.
// - Select strobe latches control, gain and mode settings.
// - Loaded bit 10 one selects sequential scan, zero random.
// - A true tested condition drives a skip request on the bus.
// - Received bus timing pulse is the internal sync signal.
// - Count-done skip test with flag set requests a skip.
// - Set count-done flag once the requested word count has moved.
// - Transfer count end stops operation and starts an interrupt.
// - Data overflow sets sign-change flag only when bit 6 was one.
`timescale 1ns/100ps
module iobf_top
    import iobf_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  wire iobf_pkg::iobf_pins_in_s  pins_in,
    output iobf_pkg::iobf_pins_out_s      pins_out,
    input  wire logic                 mem_add_valid,
    input  wire logic                 mem_old_sign,
    input  wire logic                 mem_new_sign,
    input  wire logic                 word_ready,
    output iobf_pkg::iobf_mode_s          mode,
    output logic                      run,
    output logic                      irq
);
    import iobf_pkg::*;

    localparam int PW = $bits(iobf_pins_in_s);

    logic [PW-1:0]        pin_s1_reg;
    logic [PW-1:0]        pin_s2_reg;
    logic [PW-1:0]        pin_s3_reg;
    logic [PW-1:0]        pin_filt_reg;
    logic [PW-1:0]        pin_agree;
    iobf_pins_in_s        pf;
    iobf_pins_in_s        pf_prev_reg;
    logic                 pclr;
    logic                 sync_rise;
    logic                 strobe_rise;
    logic                 read_rise;
    logic                 write_rise;
    logic                 count_end_rise;
    logic [1:0]           sd_code;
    logic                 subdevice_line_low;
    logic                 subdevice_line_high;
    logic                 sign_change_skip_test;
    logic                 count_done_skip_test;
    logic [2:0]           ctrl_reg;
    logic [IOBF_NEV-1:0]  stat_reg;
    logic [IOBF_NEV-1:0]  mask_reg;
    logic [IOBF_NEV-1:0]  ev_set;
    logic [IOBF_NEV-1:0]  ev_clr;
    logic                 rd_pend_reg;
    logic                 wr_pend_reg;
    logic                 wr_en_reg;
    logic [IOBF_AW-1:0]   wr_addr_reg;
    logic                 acc_ok;
    logic                 sign_flag;
    logic                 count_done_flag;
    logic [31:0]          rd_next;

    // Three-stage pin sampler; a bit changes once stages two and three agree
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            pin_s3_reg   <= '0;
            pin_filt_reg <= '0;
        end else if (clk_en) begin
            pin_s1_reg   <= pins_in;
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_filt_reg <= (pin_s3_reg & pin_agree) | (pin_filt_reg & ~pin_agree);
        end
    end

    assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
    assign pf        = iobf_pins_in_s'(pin_filt_reg);

    // Previous filtered pins for edge detection
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pf_prev_reg <= '0;
        end else if (clk_en) begin
            pf_prev_reg <= pf;
        end
    end

    // Power clear level and edges of the received bus pulses
    assign pclr           = pf.power_clear;
    assign sync_rise      = pf.io_sync & ~pf_prev_reg.io_sync;
    assign strobe_rise    = pf.select_strobe & ~pf_prev_reg.select_strobe & pf.device_match;
    assign read_rise      = pf.read_pulse & ~pf_prev_reg.read_pulse & pf.device_match;
    assign write_rise     = pf.write_pulse & ~pf_prev_reg.write_pulse & pf.device_match;
    assign count_end_rise = pf.transfer_count_end & ~pf_prev_reg.transfer_count_end;

    // Subdevice decode from instruction bits
    assign sd_code             = {pf.io_bus[IOBF_BIT_SD_HI], pf.io_bus[IOBF_BIT_SD_LO]};
    assign subdevice_line_low  = pf.device_match & (sd_code == IOBF_SD_SIGN);
    assign subdevice_line_high = pf.device_match & (sd_code == IOBF_SD_COUNT);

    // Flag skip tests
    assign sign_flag             = stat_reg[IOBF_EV_SIGN];
    assign count_done_flag       = stat_reg[IOBF_EV_COUNT];
    assign sign_change_skip_test = pf.flag_test_pulse & subdevice_line_low;
    assign count_done_skip_test  = pf.flag_test_pulse & subdevice_line_high;

    // Select strobe latches mode settings
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= '0;
        end else if (clk_en) begin
            if (pclr) begin
                mode <= '0;
            end else if (strobe_rise) begin
                mode.scan_order_select <= pf.io_bus[IOBF_BIT_SCAN];
                mode.mem_en            <= pf.io_bus[IOBF_BIT_MEM_EN];
                mode.ext_sync          <= pf.io_bus[IOBF_BIT_EXT];
                mode.gain              <= {pf.io_bus[IOBF_BIT_GAIN1], pf.io_bus[IOBF_BIT_GAIN0]};
            end
        end
    end

    // Event sources; set beats clear
    always_comb begin
        ev_set = '0;
        ev_set[IOBF_EV_SIGN]  = mem_add_valid & mode.mem_en & (mem_old_sign != mem_new_sign);
        ev_set[IOBF_EV_COUNT] = count_end_rise;
        ev_set[IOBF_EV_WORD]  = word_ready & ctrl_reg[IOBF_CTRL_RUN];
    end

    assign ev_clr = (wr_en_reg && wr_addr_reg == IOBF_STAT_OFS) ? hwdata[IOBF_NEV-1:0] : '0;

    // Sticky status flags, write one to clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_reg <= IOBF_EV_RST;
        end else if (clk_en) begin
            if (pclr) begin
                stat_reg <= IOBF_EV_RST;
            end else begin
                stat_reg <= (stat_reg & ~ev_clr) | ev_set;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= IOBF_EV_RST;
        end else if (clk_en) begin
            if (pclr) begin
                mask_reg <= IOBF_EV_RST;
            end else if (wr_en_reg && wr_addr_reg == IOBF_MASK_OFS) begin
                mask_reg <= hwdata[IOBF_NEV-1:0];
            end
        end
    end

    // Control register; count end stops the run
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= IOBF_CTRL_RST;
        end else if (clk_en) begin
            if (pclr) begin
                ctrl_reg <= IOBF_CTRL_RST;
            end else begin
                if (wr_en_reg && wr_addr_reg == IOBF_CTRL_OFS) begin
                    ctrl_reg <= hwdata[2:0];
                end
                // Hardware events win over a write in the same cycle
                if (count_end_rise) begin
                    ctrl_reg[IOBF_CTRL_RUN] <= 1'b0;
                end
                if (write_rise) begin
                    ctrl_reg[IOBF_CTRL_WR_ARM] <= 1'b0;
                end
            end
        end
    end

    // Pending transfer requests, served by the host pulses
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (pclr) begin
                rd_pend_reg <= 1'b0;
                wr_pend_reg <= 1'b0;
            end else begin
                if (ev_set[IOBF_EV_WORD]) begin
                    rd_pend_reg <= 1'b1;
                end else if (read_rise) begin
                    rd_pend_reg <= 1'b0;
                end
                wr_pend_reg <= ctrl_reg[IOBF_CTRL_WR_ARM] & ctrl_reg[IOBF_CTRL_RUN] & ~write_rise;
            end
        end
    end

    // Bus requests rise only on the received sync pulse; an addressed read or write pulse drops its request at once
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_out.service_interrupt_bus_request <= 1'b0;
            pins_out.device_to_host_bus_request    <= 1'b0;
            pins_out.host_to_device_bus_request    <= 1'b0;
        end else if (clk_en) begin
            if (pclr) begin
                pins_out.service_interrupt_bus_request <= 1'b0;
                pins_out.device_to_host_bus_request    <= 1'b0;
                pins_out.host_to_device_bus_request    <= 1'b0;
            end else if (sync_rise) begin
                pins_out.service_interrupt_bus_request <= ctrl_reg[IOBF_CTRL_INT_EN] &
                                                          (sign_flag | count_done_flag);
                pins_out.device_to_host_bus_request    <= rd_pend_reg & ~read_rise;
                pins_out.host_to_device_bus_request    <= wr_pend_reg & ~write_rise;
            end else begin
                if (read_rise) begin
                    pins_out.device_to_host_bus_request <= 1'b0;
                end
                if (write_rise) begin
                    pins_out.host_to_device_bus_request <= 1'b0;
                end
            end
        end
    end

    // Skip request only inside an addressed flag test pulse
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_out.skip_bus_request <= 1'b0;
        end else if (clk_en) begin
            if (pclr) begin
                pins_out.skip_bus_request <= 1'b0;
            end else begin
                pins_out.skip_bus_request <= (sign_change_skip_test & sign_flag) |
                                             (count_done_skip_test & count_done_flag);
            end
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
            run <= 1'b0;
        end else if (clk_en) begin
            irq <= |(stat_reg & mask_reg);
            run <= ctrl_reg[IOBF_CTRL_RUN];
        end
    end

    // AHB-Lite address phase acceptance
    assign acc_ok = hsel & hready & (htrans == IOBF_HTRANS_NONSEQ || htrans == IOBF_HTRANS_SEQ);

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 32'h0;
        if (haddr[IOBF_AW-1:0] == IOBF_CTRL_OFS) begin
            rd_next[2:0] = ctrl_reg;
        end else if (haddr[IOBF_AW-1:0] == IOBF_MODE_OFS) begin
            rd_next[$bits(iobf_mode_s)-1:0] = mode;
        end else if (haddr[IOBF_AW-1:0] == IOBF_STAT_OFS) begin
            rd_next[IOBF_NEV-1:0] = stat_reg;
        end else if (haddr[IOBF_AW-1:0] == IOBF_MASK_OFS) begin
            rd_next[IOBF_NEV-1:0] = mask_reg;
        end else if (haddr[IOBF_AW-1:0] == IOBF_STATE_OFS) begin
            rd_next[7:0] = {pf.io_sync, subdevice_line_high, subdevice_line_low, rd_pend_reg,
                            pins_out};
        end
    end

    // Zero-wait slave: read data and write address captured in the address phase
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata      <= 32'h0;
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= '0;
            hreadyout   <= 1'b1;
            hresp       <= IOBF_HRESP_OKAY;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= IOBF_HRESP_OKAY;
            if (hready) begin
                wr_en_reg <= acc_ok & hwrite & (haddr[31:IOBF_AW] == '0);
                wr_addr_reg <= haddr[IOBF_AW-1:0];
                if (acc_ok && !hwrite && haddr[31:IOBF_AW] == '0) begin
                    hrdata <= rd_next;
                end else begin
                    hrdata <= 32'h0;
                end
            end
        end
    end
endmodule : iobf_top
